//--- rtl/stc_channel_decode.sv
`timescale 1ns/1ps
module stc_channel_decode (
  // Channel word and texel
  input wire logic [stc_pkg::STC_WORD_W-1:0] word,
  input wire logic [stc_pkg::STC_TEXEL_W-1:0] texel,
  input wire logic is_signed,
  // Decoded value
  output logic [stc_pkg::STC_RES_W-1:0] value
);
  import stc_pkg::*;

  wire [STC_BASE_W-1:0] base_raw = word[STC_BASE_MSB -: STC_BASE_W];
  wire [STC_MULT_W-1:0] mult = word[STC_MULT_MSB -: STC_MULT_W];
  wire [STC_TBL_W-1:0] tbl = word[STC_TBL_MSB -: STC_TBL_W];
  wire [5:0] pix_lsb = 6'(STC_PIX_FIRST_LSB - STC_PIX_W * int'(texel));
  wire [STC_PIX_W-1:0] pix = word[pix_lsb +: STC_PIX_W];

  // The forbidden code is remapped before it can skew the sum
  wire [STC_BASE_W-1:0] base_fix = (base_raw == STC_BASE_FORBID) ? STC_BASE_SUBST : base_raw;
  wire [STC_SUM_W-1:0] base_signed = {{(STC_SUM_W-STC_BASE_W-STC_SHIFT){base_fix[STC_BASE_W-1]}},
                                      base_fix, {STC_SHIFT{1'b0}}};
  wire [STC_SUM_W-1:0] base_unsigned = {{(STC_SUM_W-STC_BASE_W-STC_SHIFT){1'b0}},
                                        base_raw, STC_ROUND_BITS};
  wire signed [STC_SUM_W-1:0] base_term = is_signed ? base_signed : base_unsigned;

  wire stc_mod_t modv = STC_MOD_ROM[tbl][pix];
  wire signed [STC_SUM_W-1:0] mod_ext = STC_SUM_W'(modv);
  wire signed [STC_SUM_W-1:0] prod = mod_ext * $signed({1'b0, mult});
  wire signed [STC_SUM_W-1:0] mod_term = (mult != '0) ? (prod <<< STC_SHIFT) : mod_ext;

  wire signed [STC_SUM_W-1:0] sum = base_term + mod_term;
  wire signed [STC_SUM_W-1:0] lo = is_signed ? STC_SMIN : STC_UMIN;
  wire signed [STC_SUM_W-1:0] hi = is_signed ? STC_SMAX : STC_UMAX;
  wire signed [STC_SUM_W-1:0] clamped = (sum < lo) ? lo : ((sum > hi) ? hi : sum);

  assign value = clamped[STC_RES_W-1:0];
endmodule

//--- rtl/stc_pkg.sv
package stc_pkg;

  // Block and word geometry
  localparam int STC_BLOCK_W = 128;
  localparam int STC_WORD_W = 64;
  localparam int STC_TEXEL_W = 4;
  localparam int STC_RES_W = 11;
  localparam int STC_MAG_W = 10;
  localparam int STC_SUM_W = 14;
  localparam int STC_WIDE_W = 16;

  // Field positions inside one 64-bit channel word
  localparam int STC_BASE_MSB = 63;
  localparam int STC_BASE_W = 8;
  localparam int STC_MULT_MSB = 55;
  localparam int STC_MULT_W = 4;
  localparam int STC_TBL_MSB = 51;
  localparam int STC_TBL_W = 4;
  localparam int STC_PIX_W = 3;
  localparam int STC_PIX_FIRST_LSB = 45;
  localparam int STC_MOD_W = 5;
  localparam int STC_SHIFT = 3;

  // Base codeword handling
  localparam logic [STC_SHIFT-1:0] STC_ROUND_BITS = 3'h4;
  localparam logic [STC_BASE_W-1:0] STC_BASE_FORBID = 8'h80;
  localparam logic [STC_BASE_W-1:0] STC_BASE_SUBST = 8'h81;

  // Clamp limits
  localparam logic signed [STC_SUM_W-1:0] STC_UMIN = 14'sh0000;
  localparam logic signed [STC_SUM_W-1:0] STC_UMAX = 14'sh07ff;
  localparam logic signed [STC_SUM_W-1:0] STC_SMIN = -14'sh03ff;
  localparam logic signed [STC_SUM_W-1:0] STC_SMAX = 14'sh03ff;

  // Sixteen modifier tables, entry 0 is the leftmost
  typedef logic signed [STC_MOD_W-1:0] stc_mod_t;
  localparam stc_mod_t STC_MOD_ROM [16][8] = '{
    '{-5'sd3, -5'sd6, -5'sd9, -5'sd15, 5'sd2, 5'sd5, 5'sd8, 5'sd14},
    '{-5'sd3, -5'sd7, -5'sd10, -5'sd13, 5'sd2, 5'sd6, 5'sd9, 5'sd12},
    '{-5'sd2, -5'sd5, -5'sd8, -5'sd13, 5'sd1, 5'sd4, 5'sd7, 5'sd12},
    '{-5'sd2, -5'sd4, -5'sd6, -5'sd13, 5'sd1, 5'sd3, 5'sd5, 5'sd12},
    '{-5'sd3, -5'sd6, -5'sd8, -5'sd12, 5'sd2, 5'sd5, 5'sd7, 5'sd11},
    '{-5'sd3, -5'sd7, -5'sd9, -5'sd11, 5'sd2, 5'sd6, 5'sd8, 5'sd10},
    '{-5'sd4, -5'sd7, -5'sd8, -5'sd11, 5'sd3, 5'sd6, 5'sd7, 5'sd10},
    '{-5'sd3, -5'sd5, -5'sd8, -5'sd11, 5'sd2, 5'sd4, 5'sd7, 5'sd10},
    '{-5'sd2, -5'sd6, -5'sd8, -5'sd10, 5'sd1, 5'sd5, 5'sd7, 5'sd9},
    '{-5'sd2, -5'sd5, -5'sd8, -5'sd10, 5'sd1, 5'sd4, 5'sd7, 5'sd9},
    '{-5'sd2, -5'sd4, -5'sd8, -5'sd10, 5'sd1, 5'sd3, 5'sd7, 5'sd9},
    '{-5'sd2, -5'sd5, -5'sd7, -5'sd10, 5'sd1, 5'sd4, 5'sd6, 5'sd9},
    '{-5'sd3, -5'sd4, -5'sd7, -5'sd10, 5'sd2, 5'sd3, 5'sd6, 5'sd9},
    '{-5'sd1, -5'sd2, -5'sd3, -5'sd10, 5'sd0, 5'sd1, 5'sd2, 5'sd9},
    '{-5'sd4, -5'sd6, -5'sd8, -5'sd9, 5'sd3, 5'sd5, 5'sd7, 5'sd8},
    '{-5'sd3, -5'sd5, -5'sd7, -5'sd9, 5'sd2, 5'sd4, 5'sd6, 5'sd8}
  };

  // Known table entries used by the self-checks
  localparam logic [STC_TBL_W-1:0] STC_CHK_TBL = 4'hd;
  localparam logic [STC_PIX_W-1:0] STC_CHK_PIX_NEG = 3'h3;
  localparam logic [STC_PIX_W-1:0] STC_CHK_PIX_ZERO = 3'h4;
  localparam logic [STC_RES_W-1:0] STC_CHK_MOD_MAG = 11'h00a;
  localparam logic [STC_BASE_W-1:0] STC_CHK_BASE_MIN = 8'h02;

  typedef enum logic [1:0] {
    STC_UNSIGNED_ONE_CHANNEL_FORMAT,
    STC_UNSIGNED_TWO_CHANNEL_FORMAT,
    STC_SIGNED_ONE_CHANNEL_FORMAT
  } stc_fmt_e;

  typedef struct packed {
    stc_fmt_e fmt;
    logic [STC_TEXEL_W-1:0] texel;
    logic [STC_BLOCK_W-1:0] block;
  } stc_req_s;

  typedef struct packed {
    logic [STC_RES_W-1:0] red;
    logic [STC_RES_W-1:0] green;
  } stc_rsp_s;

endpackage

//--- rtl/stc_texel_decoder.sv
`timescale 1ns/1ps
// Function
// - Two-channel unsigned block is 16 bytes, first byte is top of red word.
// - First word decodes red, second word green, each independently.
// - Unsigned base term is codeword times eight plus four.
// - Signed block is 8 bytes, first byte is word MSB.
// - Top 16 bits hold base, table, multiplier; low 48 bits texel indices.
// - Signed result is 11-bit two's complement, plus/minus 1023 full scale.
// - Signed base is two's complement; minus 128 becomes minus 127.
// - Signed base term is codeword times eight, no offset.
// - Table index from bits 51..48 selects one of sixteen tables.
// - Texel index from bits 47..0, texel one at bits 44..42.
// - Index counts from leftmost entry; table 13 index 3 gives minus 10.
// - Nonzero multiplier from bits 55..52 scales modifier, then times eight.
// - Signed sum saturates to minus 1023 .. plus 1023.
// - Zero multiplier adds the modifier unscaled, still clamped.
// - Non-negative signed result widens as x<<5 plus x>>5.
// - Negative result is negated, widened, then negated back.
// - Other output widths use the same sign-aware replication.
// - Never deliver fewer than eleven result bits.
// - Shared datapath switches offset, clamp and widening by format.
module stc_texel_decoder #(
  parameter int WIDE_W = stc_pkg::STC_WIDE_W
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Request
  input wire logic req_valid,
  input wire stc_pkg::stc_req_s req,
  // Answer
  output logic rsp_valid,
  output stc_pkg::stc_rsp_s rsp,
  output logic [WIDE_W-1:0] red_wide,
  output logic [WIDE_W-1:0] green_wide
);
  import stc_pkg::*;

  // Request stage
  stc_req_s req_reg;
  logic vld_reg;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      req_reg <= '0;
      vld_reg <= 1'b0;
    end else begin
      req_reg <= req;
      vld_reg <= req_valid;
    end
  end

  // Format decode
  wire fmt_signed = (req_reg.fmt == STC_SIGNED_ONE_CHANNEL_FORMAT);
  wire fmt_two = (req_reg.fmt == STC_UNSIGNED_TWO_CHANNEL_FORMAT);

  // Lowest-addressed byte sits in block bits 127..120, so it lands on top of the red word
  wire [STC_WORD_W-1:0] red_word = req_reg.block[STC_BLOCK_W-1 -: STC_WORD_W];
  wire [STC_WORD_W-1:0] green_word = req_reg.block[STC_WORD_W-1:0];

  logic [STC_RES_W-1:0] red_val;
  logic [STC_RES_W-1:0] green_val;

  stc_channel_decode u_red (
    .word(red_word),
    .texel(req_reg.texel),
    .is_signed(fmt_signed),
    .value(red_val)
  );

  // Green always decodes as unsigned; the one-channel formats blank it below
  stc_channel_decode u_green (
    .word(green_word),
    .texel(req_reg.texel),
    .is_signed(1'b0),
    .value(green_val)
  );

  wire [STC_RES_W-1:0] green_sel = fmt_two ? green_val : '0;

  // Sign-aware bit replication to WIDE_W bits; WIDE_W below 11 is rejected at elaboration
  function automatic logic [WIDE_W-1:0] widen(input logic [STC_RES_W-1:0] x, input logic sgn);
    logic [WIDE_W-1:0] r;
    logic [STC_MAG_W-1:0] mag;
    logic neg;
    r = '0;
    neg = sgn & x[STC_RES_W-1];
    mag = neg ? STC_MAG_W'(-x) : x[STC_MAG_W-1:0];
    for (int i = 0; i < WIDE_W; i++) begin
      if (sgn) begin
        if (i < WIDE_W - 1) begin
          r[WIDE_W-2-i] = mag[STC_MAG_W-1-(i % STC_MAG_W)];
        end
      end else begin
        r[WIDE_W-1-i] = x[STC_RES_W-1-(i % STC_RES_W)];
      end
    end
    return neg ? -r : r;
  endfunction

  wire [WIDE_W-1:0] red_wide_next = widen(red_val, fmt_signed);
  wire [WIDE_W-1:0] green_wide_next = widen(green_sel, 1'b0);

  if (WIDE_W < STC_RES_W) begin : g_width_guard
    $error("Widened output narrower than eleven bits");
  end

  // Answer stage
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rsp_valid <= 1'b0;
      rsp <= '0;
      red_wide <= '0;
      green_wide <= '0;
    end else begin
      rsp_valid <= vld_reg;
      rsp.red <= red_val;
      rsp.green <= green_sel;
      red_wide <= red_wide_next;
      green_wide <= green_wide_next;
    end
  end

  // Self-check helpers on the red word
  wire [STC_BASE_W-1:0] chk_base = red_word[STC_BASE_MSB -: STC_BASE_W];
  wire [STC_MULT_W-1:0] chk_mult = red_word[STC_MULT_MSB -: STC_MULT_W];
  wire [STC_TBL_W-1:0] chk_tbl = red_word[STC_TBL_MSB -: STC_TBL_W];
  wire [5:0] chk_lsb = 6'(STC_PIX_FIRST_LSB - STC_PIX_W * int'(req_reg.texel));
  wire [STC_PIX_W-1:0] chk_pix = red_word[chk_lsb +: STC_PIX_W];
  wire [STC_BASE_W-1:0] chk_base_fix = (chk_base == STC_BASE_FORBID) ? STC_BASE_SUBST : chk_base;
  wire signed [STC_RES_W-1:0] chk_base_s = STC_RES_W'($signed(chk_base_fix)) * 11'sd8;
  wire [STC_RES_W-1:0] chk_base_u = STC_RES_W'(chk_base) * 11'd8 + STC_RES_W'(STC_ROUND_BITS);
  wire [STC_RES_W-1:0] chk_base_term = fmt_signed ? chk_base_s : chk_base_u;
  wire chk_zero_mod = (chk_tbl == STC_CHK_TBL) && (chk_pix == STC_CHK_PIX_ZERO);
  wire chk_neg_mod = (chk_tbl == STC_CHK_TBL) && (chk_pix == STC_CHK_PIX_NEG);
  wire chk_halves_eq = (red_word == green_word);
  wire chk_base_neg = fmt_signed && chk_base_fix[STC_BASE_W-1];
  wire [STC_RES_W-1:0] chk_neg_scaled = STC_RES_W'((STC_CHK_MOD_MAG * chk_mult) << STC_SHIFT);
  wire [STC_RES_W-1:0] chk_scaled_res = chk_base_term - chk_neg_scaled;

  // Green word helpers share the texel position with red
  wire [STC_BASE_W-1:0] chk_g_base = green_word[STC_BASE_MSB -: STC_BASE_W];
  wire [STC_TBL_W-1:0] chk_g_tbl = green_word[STC_TBL_MSB -: STC_TBL_W];
  wire [STC_PIX_W-1:0] chk_g_pix = green_word[chk_lsb +: STC_PIX_W];
  wire [STC_RES_W-1:0] chk_g_base_u = (STC_RES_W'(chk_g_base) << STC_SHIFT) | STC_RES_W'(STC_ROUND_BITS);
  wire chk_g_zero_mod = (chk_g_tbl == STC_CHK_TBL) && (chk_g_pix == STC_CHK_PIX_ZERO);

  a_answer_latency: assert property (@(posedge clk_sys) disable iff (sys_rst)
    req_valid |=> ##1 rsp_valid)
    else $error("Answer did not follow request by two cycles");

  a_no_spurious: assert property (@(posedge clk_sys) disable iff (sys_rst)
    rsp_valid |-> $past(req_valid, 2))
    else $error("Answer without a request two cycles earlier");

  a_signed_range: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (vld_reg && fmt_signed) |=> ($signed(rsp.red) >= -11'sd1023) && ($signed(rsp.red) <= 11'sd1023))
    else $error("Signed result outside saturation range");

  a_base_term: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (vld_reg && chk_zero_mod) |=> (rsp.red == $past(chk_base_term)))
    else $error("Base term wrong for zero modifier");

  a_signed_base: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (vld_reg && fmt_signed && chk_zero_mod && chk_base == STC_BASE_FORBID)
      |=> ($signed(rsp.red) == -11'sd1016))
    else $error("Forbidden signed base not remapped");

  a_mult_zero: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (vld_reg && !fmt_signed && chk_neg_mod && chk_mult == '0 && chk_base >= STC_CHK_BASE_MIN)
      |=> (rsp.red == $past(chk_base_term) - STC_CHK_MOD_MAG))
    else $error("Zero multiplier did not add modifier unscaled");

  a_wide_pos: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (vld_reg && fmt_signed && !red_val[STC_RES_W-1])
      |=> (red_wide[WIDE_W-1 -: STC_RES_W] == rsp.red) && !red_wide[WIDE_W-1])
    else $error("Positive widening lost the result bits");

  // Negating the replicated low bits can lift the top field's magnitude by one
  a_wide_neg: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (vld_reg && fmt_signed && red_val[STC_RES_W-1])
      |=> red_wide[WIDE_W-1] && ((STC_RES_W'(-red_wide[WIDE_W-1 -: STC_RES_W]) - STC_RES_W'(-rsp.red)) <= 11'h001))
    else $error("Negative widening broke the sign or magnitude");

  a_wide_unsigned: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (vld_reg && !fmt_signed) |=> (red_wide[WIDE_W-1 -: STC_RES_W] == rsp.red)
      && (green_wide[WIDE_W-1 -: STC_RES_W] == rsp.green))
    else $error("Unsigned widening dropped result bits");

  a_channels_match: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (vld_reg && fmt_two && chk_halves_eq) |=> (rsp.red == rsp.green))
    else $error("Equal channel words decoded differently");

  a_mult_scaled: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (vld_reg && chk_neg_mod && chk_mult != '0 && !chk_base_neg && chk_base_term >= chk_neg_scaled)
      |=> (rsp.red == $past(chk_scaled_res)))
    else $error("Nonzero multiplier did not scale the modifier");

  a_unsigned_floor: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (vld_reg && !fmt_signed && chk_neg_mod && chk_mult != '0 && chk_base_term < chk_neg_scaled)
      |=> (rsp.red == '0))
    else $error("Unsigned result not clamped at zero");

  a_signed_floor: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (vld_reg && chk_base_neg && chk_neg_mod && chk_mult == '1)
      |=> (rsp.red == STC_RES_W'(STC_SMIN)))
    else $error("Signed result not saturated at the lower limit");

  a_green_blank: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (vld_reg && !fmt_two) |=> (rsp.green == '0) && (green_wide == '0))
    else $error("Green channel not blanked for a one-channel format");

  a_green_base: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (vld_reg && fmt_two && chk_g_zero_mod) |=> (rsp.green == $past(chk_g_base_u)))
    else $error("Green base term wrong for zero modifier");

  a_reset_quiet: assert property (@(posedge clk_sys)
    sys_rst |=> !rsp_valid && (rsp == '0) && (red_wide == '0) && (green_wide == '0))
    else $error("Outputs not cleared by reset");

endmodule

//--- test/stc_sink.sv
`timescale 1ns/1ps
module stc_sink (
  // Clock
  input wire logic clk_sys,
  // Decoded answer
  input wire logic rsp_valid,
  input wire stc_pkg::stc_rsp_s rsp,
  input wire logic [15:0] red_wide,
  input wire logic [15:0] green_wide
);
  import stc_pkg::*;
  // Filtering has no stall path, so every answer is taken on its one valid cycle
  logic [53:0] got [$];
  always @(posedge clk_sys) begin
    if (rsp_valid === 1'b1) begin
      got.push_back({rsp, red_wide, green_wide});
    end
  end
endmodule

//--- test/stc_texel_decoder_tb.sv
`timescale 1ns/1ps
module stc_texel_decoder_tb;
  import stc_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic req_valid = 1'b0;
  stc_req_s req = '0;
  logic rsp_valid;
  stc_rsp_s rsp;
  logic [15:0] red_wide;
  logic [15:0] green_wide;
  int fails = 0;
  int check_count = 0;
  stc_req_s q [$];

  stc_texel_decoder #(.WIDE_W(16)) DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .req_valid(req_valid),
    .req(req), .rsp_valid(rsp_valid), .rsp(rsp), .red_wide(red_wide), .green_wide(green_wide));
  stc_sink SINK (.clk_sys(clk_sys), .rsp_valid(rsp_valid), .rsp(rsp), .red_wide(red_wide),
    .green_wide(green_wide));

  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [53:0] seen, input logic [53:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic int dec(input logic [63:0] w, input logic [3:0] t, input bit sg);
    int b;
    int m;
    int k;
    int s;
    m = STC_MOD_ROM[w[51:48]][w[47-3*t -: 3]];
    k = w[55:52];
    if (sg) begin
      b = $signed(w[63:56]);
      if (b == -128) b = -127;
      b = b * 8;
    end else begin
      b = w[63:56] * 8 + 4;
    end
    if (k != 0) m = m * k * 8;
    s = b + m;
    if (sg) return (s > 1023) ? 1023 : (s < -1023) ? -1023 : s;
    return (s > 2047) ? 2047 : (s < 0) ? 0 : s;
  endfunction

  function automatic logic [15:0] widen(input int v, input bit sg);
    int a;
    if (!sg) return 16'((v << 5) + (v >> 6));
    a = (v < 0) ? -v : v;
    a = (a << 5) + (a >> 5);
    return 16'((v < 0) ? -a : a);
  endfunction

  function automatic logic [53:0] expect_of(input stc_req_s r);
    int rv;
    int gv;
    bit sg;
    sg = (r.fmt == STC_SIGNED_ONE_CHANNEL_FORMAT);
    rv = dec(r.block[127:64], r.texel, sg);
    gv = (r.fmt == STC_UNSIGNED_TWO_CHANNEL_FORMAT) ? dec(r.block[63:0], r.texel, 1'b0) : 0;
    return {11'(rv), 11'(gv), widen(rv, sg), widen(gv, 1'b0)};
  endfunction

  function automatic logic [63:0] mk(input logic [7:0] b, input logic [3:0] m, input logic [3:0] t,
    input logic [47:0] ix);
    return {b, m, t, ix};
  endfunction

  function automatic stc_req_s rq(input stc_fmt_e f, input logic [3:0] t, input logic [63:0] r,
    input logic [63:0] g);
    return '{f, t, {r, g}};
  endfunction

  // Sends the queue back to back, then compares every answer the sink saw
  task automatic run();
    int n;
    n = q.size();
    SINK.got.delete();
    foreach (q[i]) begin
      @(posedge clk_sys);
      req_valid <= 1'b1;
      req <= q[i];
    end
    @(posedge clk_sys);
    req_valid <= 1'b0;
    repeat (4) @(posedge clk_sys);
    check(54'(SINK.got.size()), 54'(n));
    foreach (q[i]) if (i < SINK.got.size()) check(SINK.got[i], expect_of(q[i]));
    q.delete();
  endtask

  task automatic s_reset_latency();
    #1 check(54'(rsp_valid), 54'h0);
    check({rsp, red_wide, green_wide}, '0);
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req <= rq(STC_UNSIGNED_ONE_CHANNEL_FORMAT, 4'h0, mk(8'h10, 4'h1, 4'hd, '0), '0);
    @(posedge clk_sys);
    req_valid <= 1'b0;
    @(posedge clk_sys);
    #1 check(54'(rsp_valid), 54'h1);
    @(posedge clk_sys);
    #1 check(54'(rsp_valid), 54'h0);
  endtask

  task automatic s_examples();
    logic [47:0] ix;
    stc_req_s ex;
    ix = 48'h0c00_0000_0000;
    q.push_back(rq(STC_SIGNED_ONE_CHANNEL_FORMAT, 4'h1, mk(8'h3c, 4'h2, 4'hd, ix), '0));
    q.push_back(rq(STC_SIGNED_ONE_CHANNEL_FORMAT, 4'h1, mk(8'h3c, 4'h0, 4'hd, ix), '0));
    q.push_back(rq(STC_UNSIGNED_ONE_CHANNEL_FORMAT, 4'h1, mk(8'h67, 4'h2, 4'hd, ix), '0));
    q.push_back(rq(STC_UNSIGNED_ONE_CHANNEL_FORMAT, 4'h1, mk(8'h67, 4'h0, 4'hd, ix), '0));
    run();
    ex = rq(STC_UNSIGNED_ONE_CHANNEL_FORMAT, 4'h1, mk(8'h67, 4'h2, 4'hd, ix), '0);
    check(expect_of(ex), {11'h29c, 11'h000, 16'h538a, 16'h0000});
    check(SINK.got[0], {11'h140, 11'h000, 16'h280a, 16'h0000});
    check(SINK.got[1], {11'h1d6, 11'h000, 16'h3ace, 16'h0000});
    check(SINK.got[2], {11'h29c, 11'h000, 16'h538a, 16'h0000});
    check(SINK.got[3], {11'h332, 11'h000, 16'h664c, 16'h0000});
  endtask

  task automatic s_clamp();
    logic [47:0] p7;
    logic [47:0] p3;
    logic [47:0] p4;
    p7 = 48'hffff_ffff_ffff;
    p3 = 48'h6db6_db6d_b6db;
    p4 = 48'h9249_2492_4924;
    q.push_back(rq(STC_SIGNED_ONE_CHANNEL_FORMAT, 4'h5, mk(8'h7f, 4'hf, 4'hd, p7), '0));
    q.push_back(rq(STC_SIGNED_ONE_CHANNEL_FORMAT, 4'h6, mk(8'h81, 4'hf, 4'hd, p3), '0));
    q.push_back(rq(STC_SIGNED_ONE_CHANNEL_FORMAT, 4'h0, mk(8'h80, 4'h0, 4'hd, p4), '0));
    q.push_back(rq(STC_SIGNED_ONE_CHANNEL_FORMAT, 4'hf, mk(8'hfe, 4'h0, 4'hd, p3), '0));
    q.push_back(rq(STC_UNSIGNED_ONE_CHANNEL_FORMAT, 4'h9, mk(8'hff, 4'hf, 4'hd, p7), '0));
    q.push_back(rq(STC_UNSIGNED_TWO_CHANNEL_FORMAT, 4'h2, mk(8'h00, 4'hf, 4'hd, p3), mk(8'h00, 4'h0, 4'h0, p3)));
    q.push_back(rq(STC_UNSIGNED_TWO_CHANNEL_FORMAT, 4'h7, mk(8'h40, 4'h3, 4'hd, p4), mk(8'h40, 4'h3, 4'hd, p4)));
    run();
    check(SINK.got[0], {11'h3ff, 11'h000, 16'h7fff, 16'h0000});
    check(SINK.got[1], {11'h401, 11'h000, 16'h8001, 16'h0000});
    check(SINK.got[2], {11'h408, 11'h000, 16'h80e1, 16'h0000});
    check(SINK.got[6], {11'h204, 11'h204, 16'h4088, 16'h4088});
  endtask

  // Every texel of one block in every format code, back to back
  task automatic s_texels();
    logic [63:0] r;
    logic [63:0] g;
    r = mk(8'h55, 4'h3, 4'h2, 48'h0539_77ac_2e6f);
    g = mk(8'hc3, 4'h1, 4'h9, 48'hfa86_13d0_5b24);
    for (int t = 0; t < 16; t++) begin
      for (int f = 0; f < 4; f++) q.push_back(rq(stc_fmt_e'(f), 4'(t), r, g));
    end
    run();
  endtask

  task automatic s_mid_reset();
    SINK.got.delete();
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req <= rq(STC_SIGNED_ONE_CHANNEL_FORMAT, 4'h3, mk(8'h20, 4'h1, 4'h1, '1), '0);
    @(posedge clk_sys);
    req_valid <= 1'b0;
    sys_rst <= 1'b1;
    @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    check(54'(SINK.got.size()), 54'h0);
    q.push_back(rq(STC_SIGNED_ONE_CHANNEL_FORMAT, 4'h3, mk(8'h20, 4'h1, 4'h1, '1), '0));
    run();
  endtask

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    #(25 * 20000);
    fails++;
    final_report();
  end

  initial begin
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    s_reset_latency();
    s_examples();
    s_clamp();
    s_texels();
    s_mid_reset();
    final_report();
  end
endmodule
